// File: rtl/interrupt_request_vector_map.sv
// interrupt request generation and fixed vector mapping
// assumes all event, clear and enable inputs are on clock; one source per vector
//
// Operation
// - each source sets its own sticky flag when its condition occurs
// - each source has an enable bit written by software, on or off
// - request for a maskable source is flag AND enable; the nmi request is its flag alone
// - request holds until flag cleared; vector entry alone does not clear it
// - no maskable request reaches the core without global enable
// - each vector serves exactly one source instance
// - vector 1 at address 0x02 is memory-scan NMI; vector 0 is reset
// - timer A: overflow 7, underflow 8, compare 9, 10, 11
`include "irq_vector_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module interrupt_request_vector_map (
   input  wire logic                        clock,
   input  wire logic                        rstn,
   input  wire irq_vector_pkg::vec_mask_t   source_event,
   input  wire irq_vector_pkg::vec_mask_t   flag_clear,
   input  wire logic                        enable_write,
   input  wire irq_vector_pkg::vec_mask_t   enable_wdata,
   input  wire logic                        global_enable,
   output irq_vector_pkg::vec_mask_t        source_flag_register,
   output irq_vector_pkg::vec_mask_t        source_enable_register,
   output irq_vector_pkg::vec_mask_t        request_lines,
   output logic                             request_valid,
   output irq_vector_pkg::vec_num_t         vector_number,
   output irq_vector_pkg::vec_addr_t        vector_address
);
   irq_vector_pkg::vec_mask_t flag_reg;
   irq_vector_pkg::vec_mask_t flag_next;
   irq_vector_pkg::vec_mask_t enable_reg;
   irq_vector_pkg::vec_mask_t enable_next;
   irq_vector_pkg::vec_mask_t pending;
   irq_vector_pkg::vec_mask_t gate;
   irq_vector_pkg::vec_num_t  sel_num;
   logic                      sel_any;
   irq_vector_pkg::vec_num_t  num_reg;
   logic                      valid_reg;

   // only the reset vector slot 0 never holds a flag; unused low slots 2 to 6 can still hold one
   localparam irq_vector_pkg::vec_mask_t source_exists = ~24'h00_0001;

   // set wins over clear so an event in the clearing cycle is kept
   assign flag_next   = ((flag_reg & ~flag_clear) | source_event) & source_exists;
   assign enable_next = enable_write ? enable_wdata : enable_reg;

   // nmi bypasses both enable and global enable; everything else is maskable
   genvar g;
   generate
      for (g = 0; g < `VEC_COUNT; g = g + 1) begin : gate_gen
         if (g == 1) begin : nmi_g
            assign gate[g] = 1'b1;
         end else begin : mask_g
            assign gate[g] = enable_reg[g] & global_enable;
         end
      end
   endgenerate
   assign pending = flag_reg & gate;

   // lowest number wins, one bit per vector so each maps one source
   always_comb begin
      sel_num = `VEC_RESET;
      sel_any = 1'b0;
      for (int i = `VEC_COUNT - 1; i >= 1; i--) begin
         if (pending[i]) begin
            sel_num = i[`VEC_NUM_W-1:0];
            sel_any = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flag_reg   <= `FLAGS_RESET;
         enable_reg <= `ENABLE_RESET;
         num_reg    <= `VEC_RESET;
         valid_reg  <= 1'b0;
      end else begin
         flag_reg   <= flag_next;
         enable_reg <= enable_next;
         num_reg    <= sel_num;
         valid_reg  <= sel_any;
      end
   end

   assign source_flag_register   = flag_reg;
   assign source_enable_register = enable_reg;
   assign request_lines          = pending;
   assign request_valid          = valid_reg;
   assign vector_number          = num_reg;
   assign vector_address         = {num_reg, 1'b0};

   property flag_sticky_p;
      @(posedge clock) disable iff (!rstn)
         (flag_reg[3] && !flag_clear[3]) |=> flag_reg[3];
   endproperty
   flag_sticky_a: assert property (flag_sticky_p) else $error("flag dropped without clear");

   event_sets_a: assert property (@(posedge clock) disable iff (!rstn)
      source_event[9] |=> flag_reg[9]) else $error("event did not set flag");

   set_over_clear_a: assert property (@(posedge clock) disable iff (!rstn)
      (source_event[7] && flag_clear[7]) |=> flag_reg[7]) else $error("clear beat set");

   enable_write_a: assert property (@(posedge clock) disable iff (!rstn)
      enable_write |=> enable_reg == $past(enable_wdata)) else $error("enable not written");

   and_gate_a: assert property (@(posedge clock) disable iff (!rstn)
      request_lines[11] == (flag_reg[11] && enable_reg[11] && global_enable)) else $error("bad request");

   global_mask_a: assert property (@(posedge clock) disable iff (!rstn)
      !global_enable |-> (request_lines & ~24'h00_0002) == 24'h00_0000) else $error("masked leak");

   nmi_path_a: assert property (@(posedge clock) disable iff (!rstn)
      flag_reg[1] |=> request_valid && vector_number == 5'h01 && vector_address == 6'h02)
      else $error("nmi not presented");

   sequence tca_ovf_s;
      pending == 24'h00_0080;
   endsequence
   tca_map_a: assert property (@(posedge clock) disable iff (!rstn)
      tca_ovf_s |=> vector_number == 5'h07 && vector_address == 6'h0E) else $error("timer map wrong");

   addr_twice_a: assert property (@(posedge clock) disable iff (!rstn)
      vector_address == 6'(2 * vector_number)) else $error("address not twice number");

   no_reset_flag_a: assert property (@(posedge clock) disable iff (!rstn)
      !flag_reg[0]) else $error("reset slot flagged");

   no_reset_request_a: assert property (@(posedge clock) disable iff (!rstn)
      !request_lines[0]) else $error("reset slot requested");

   clear_drops_a: assert property (@(posedge clock) disable iff (!rstn)
      (flag_clear[4] && !source_event[4]) |=> !flag_reg[4]) else $error("clear ignored");

   // the core taking a vector must not disturb the flag behind it
   no_vector_clear_a: assert property (@(posedge clock) disable iff (!rstn)
      (request_valid && flag_reg[8] && !flag_clear[8]) |=> flag_reg[8])
      else $error("vector entry cleared flag");

   enable_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      !enable_write |=> $stable(enable_reg)) else $error("enable changed unwritten");

   nmi_unmasked_a: assert property (@(posedge clock) disable iff (!rstn)
      (!global_enable && flag_reg[1]) |-> request_lines[1]) else $error("nmi masked");

   sequence pend_any_s;
      pending != 24'h00_0000;
   endsequence
   sequence pend_none_s;
      pending == 24'h00_0000;
   endsequence
   valid_follows_a: assert property (@(posedge clock) disable iff (!rstn)
      pend_any_s |=> request_valid) else $error("pending not presented");

   idle_valid_a: assert property (@(posedge clock) disable iff (!rstn)
      pend_none_s |=> !request_valid && vector_number == `VEC_RESET) else $error("idle vector shown");

   // two timer sources at once: the lower number is the one presented
   lowest_wins_a: assert property (@(posedge clock) disable iff (!rstn)
      (pending[7] && pending[9]) |=> vector_number <= 5'h07) else $error("priority wrong");

   vector_range_a: assert property (@(posedge clock) disable iff (!rstn)
      vector_number < 5'h18) else $error("vector out of range");

   sequence tca_unf_s;
      pending == 24'h00_0100;
   endsequence
   sequence tca_cmp0_s;
      pending == 24'h00_0200;
   endsequence
   sequence tca_cmp1_s;
      pending == 24'h00_0400;
   endsequence
   sequence tca_cmp2_s;
      pending == 24'h00_0800;
   endsequence

   tca_unf_map_a: assert property (@(posedge clock) disable iff (!rstn)
      tca_unf_s |=> vector_number == `VEC_TCA_UNF && vector_address == 6'h10)
      else $error("underflow map wrong");

   tca_cmp0_map_a: assert property (@(posedge clock) disable iff (!rstn)
      tca_cmp0_s |=> vector_number == `VEC_TCA_CMP0 && vector_address == 6'h12)
      else $error("compare 0 map wrong");

   tca_cmp1_map_a: assert property (@(posedge clock) disable iff (!rstn)
      tca_cmp1_s |=> vector_number == `VEC_TCA_CMP1 && vector_address == 6'h14)
      else $error("compare 1 map wrong");

   tca_cmp2_map_a: assert property (@(posedge clock) disable iff (!rstn)
      tca_cmp2_s |=> vector_number == `VEC_TCA_CMP2 && vector_address == 6'h16)
      else $error("compare 2 map wrong");

   // every maskable slot is checked alike; slot 1 has its own nmi checks
   genvar k;
   generate
      for (k = 2; k < `VEC_COUNT; k = k + 1) begin : per_vec_chk
         req_and_a: assert property (@(posedge clock) disable iff (!rstn)
            request_lines[k] == (flag_reg[k] && enable_reg[k] && global_enable))
            else $error("request not flag and enable");

         flag_hold_a: assert property (@(posedge clock) disable iff (!rstn)
            (flag_reg[k] && !flag_clear[k]) |=> flag_reg[k])
            else $error("flag dropped");

         event_keep_a: assert property (@(posedge clock) disable iff (!rstn)
            source_event[k] |=> flag_reg[k])
            else $error("event lost");
      end
   endgenerate
endmodule
`default_nettype wire

// File: rtl/irq_vector_regs.svh
// constants for the interrupt request and vector map block
// assumes inclusion by bare name from rtl/
`ifndef IRQ_VECTOR_REGS_SVH
`define IRQ_VECTOR_REGS_SVH
`define VEC_COUNT       24
`define VEC_NUM_W       5
`define VEC_ADDR_W      6
`define VEC_RESET       5'h00
`define VEC_NMI         5'h01
`define VEC_TCA_OVF     5'h07
`define VEC_TCA_UNF     5'h08
`define VEC_TCA_CMP0    5'h09
`define VEC_TCA_CMP1    5'h0A
`define VEC_TCA_CMP2    5'h0B
`define VEC_FIRST_MASK  2
`define FLAGS_RESET     24'h00_0000
`define ENABLE_RESET    24'h00_0000
`endif

// File: rtl/irq_vector_pkg.sv
// types for the interrupt request and vector map block
// assumes irq_vector_regs.svh sits beside it
`include "irq_vector_regs.svh"
package irq_vector_pkg;
   typedef logic [`VEC_NUM_W-1:0]  vec_num_t;
   typedef logic [`VEC_ADDR_W-1:0] vec_addr_t;
   typedef logic [`VEC_COUNT-1:0]  vec_mask_t;
endpackage

// File: verification/cpu_model.sv
// processor side model: latches the vector fetched on each new request
// assumes request_valid and vector_number are registered on clock
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
   input  wire logic                     clock,
   input  wire logic                     request_valid,
   input  wire irq_vector_pkg::vec_num_t vector_number,
   output irq_vector_pkg::vec_num_t      fetched
);
   logic was_reg;
   always_ff @(posedge clock) begin
      was_reg <= request_valid;
      if (request_valid && !was_reg) fetched <= vector_number;
   end
endmodule
`default_nettype wire

// File: verification/interrupt_request_vector_map_tb.sv
// self-checking bench for the request and vector map block
// assumes the package is compiled first
`timescale 1ns/1ps
`default_nettype none
module interrupt_request_vector_map_tb;
   logic clock = 0, rstn = 0, enable_write = 0, global_enable = 0, request_valid, prev = 0;
   irq_vector_pkg::vec_mask_t source_event = '0, flag_clear = '0, enable_wdata = '0, flags, enables, lines;
   irq_vector_pkg::vec_num_t  vector_number, seen;
   irq_vector_pkg::vec_addr_t vector_address;
   logic [10:0] notes[$];
   integer bad_count = 0, comparisons = 0, seed = 32'heae3f2f7, cycles = 0, v;
   int list[] = '{1, 2, 7, 8, 9, 10, 11, 23};
   interrupt_request_vector_map uut (.clock(clock), .rstn(rstn), .source_event(source_event),
      .flag_clear(flag_clear), .enable_write(enable_write), .enable_wdata(enable_wdata),
      .global_enable(global_enable), .source_flag_register(flags), .source_enable_register(enables),
      .request_lines(lines), .request_valid(request_valid), .vector_number(vector_number),
      .vector_address(vector_address));
   cpu_model core (.clock(clock), .request_valid(request_valid), .vector_number(vector_number), .fetched(seen));
   initial begin
      forever #50 clock = ~clock;
   end
   task check(input logic ok, input string msg);
      comparisons++;
      if (!ok) begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task summarize;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task pulse(input int b, input logic clr);
      @(posedge clock);
      if (clr) flag_clear[b] <= 1'b1;
      else source_event[b] <= 1'b1;
      @(posedge clock);
      flag_clear <= '0;
      source_event <= '0;
      repeat (4) @(posedge clock);
      @(negedge clock);
   endtask
   // vector notes are popped only on a rising request, so each entry is one fetch
   always @(negedge clock) begin
      prev <= request_valid;
      if (request_valid === 1'b1 && prev !== 1'b1) check(notes.size() > 0 && {vector_number, vector_address} === notes.pop_front(), "vector");
   end
   always @(posedge clock) if (++cycles > 3000) begin bad_count++; summarize(); end
   initial begin
      repeat (4) @(posedge clock);
      rstn <= 1;
      enable_write <= 1;
      enable_wdata <= '1;
      global_enable <= 1;
      @(posedge clock);
      enable_write <= 0;
      foreach (list[i]) begin
         v = list[i];
         notes.push_back({v[4:0], v[4:0], 1'b0});
         pulse(v, 0);
         check(lines[v] === 1'b1 && flags[v] === 1'b1 && seen === v[4:0], "held request");
         pulse(v, 1);
         check(flags === '0 && request_valid === 1'b0, "clear");
         $display("vector %0d done", v);
      end
      @(posedge clock);
      enable_write <= 1;
      enable_wdata <= 24'($random(seed)) & 24'hff_fff7;
      global_enable <= 0;
      @(posedge clock);
      enable_write <= 0;
      notes.push_back({5'h01, 6'h02});
      source_event[5] <= 1'b1;
      pulse(1, 0);
      check(lines[1] === 1'b1 && lines[5] === 1'b0 && flags[5] === 1'b1, "global gate");
      @(posedge clock);
      global_enable <= 1;
      pulse(3, 0);
      check(lines[3] === 1'b0 && enables[3] === 1'b0, "enable gate");
      $display("gating done");
      summarize();
   end
endmodule
`default_nettype wire
